/* rtl/osc_pkg.sv */
/*
  Package for the oscillator and operating-mode controller: register offsets,
  field positions, reset values, mode enumerations and stabilisation counts.
  Assumes a single 50 MHz bus clock; oscillator start-up is modelled by counters.
*/
package osc_pkg;

  // Register byte addresses on the bus.
  localparam logic [7:0] OFF_INT_FAST   = 8'h00;
  localparam logic [7:0] OFF_FAST_XTAL  = 8'h04;
  localparam logic [7:0] OFF_SLOW_XTAL  = 8'h08;
  localparam logic [7:0] OFF_SYS_CLK    = 8'h0c;
  localparam logic [7:0] OFF_STATUS     = 8'h10;
  localparam logic [7:0] OFF_HALT       = 8'h14;

  // Field positions.
  localparam int BIT_ENABLE    = 0;
  localparam int BIT_STABLE    = 1;
  localparam int BIT_MODE      = 2;
  localparam int BIT_FREQ_LO   = 2;
  localparam int BIT_SLOW_IDLE = 0;
  localparam int BIT_FAST_IDLE = 1;
  localparam int BIT_SLOW_SRC  = 2;
  localparam int BIT_FAST_SRC  = 3;
  localparam int BIT_CKS_LO    = 5;
  localparam int BIT_PDF       = 0;
  localparam int BIT_TO        = 1;
  localparam int BIT_WDT_EN    = 2;

  // Reset values.
  localparam logic [7:0] RST_INT_FAST  = 8'h01;
  localparam logic [7:0] RST_XTAL      = 8'h00;
  localparam logic [7:0] RST_SYS_CLK   = 8'h00;

  // Clock-select code for the slow source.
  localparam logic [2:0] CKS_SLOW = 3'h7;

  // Stabilisation times in microseconds and their cycle counts at 50 MHz.
  localparam int CLK_MHZ         = 50;
  localparam int INT_FAST_US     = 16;
  localparam int FAST_XTAL_US    = 64;
  localparam int SLOW_XTAL_US    = 80;
  localparam int INT_FAST_CYC    = INT_FAST_US * CLK_MHZ;
  localparam int FAST_XTAL_CYC   = FAST_XTAL_US * CLK_MHZ;
  localparam int SLOW_XTAL_CYC   = SLOW_XTAL_US * CLK_MHZ;

  typedef enum logic [1:0] { FREQ_8M, FREQ_12M, FREQ_16M } freq_e;
  typedef enum logic [2:0] { MODE_RUN, MODE_SLEEP, MODE_IDLE_SLOW, MODE_IDLE_BOTH, MODE_IDLE_FAST } pmode_e;

  // Bus-side signals of one AHB-Lite transfer.
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
  } ahb_req_s;

  typedef struct packed {
    logic        fast_en;    // Oscillator enable lines out.
    logic        xtal_en;
    logic        slow_en;
    logic        fast_clk_on;
    logic        slow_clk_on;
    logic        sys_slow;   // System clock taken from slow source.
    logic [2:0]  fast_div_log2;
    freq_e       freq;
  } clk_out_s;

endpackage

/* rtl/osc_ctrl.sv */
/*
  Oscillator control and power-mode controller with an AHB-Lite register slave.
  Assumes a single-master AHB-Lite bus, whole-word single transfers, and that the
  CPU pulses a halt strobe and a wake strobe; oscillator stability is counted here.
*/
`timescale 1ns/1ps
module osc_ctrl #(
  parameter int INT_FAST_CNT  = osc_pkg::INT_FAST_CYC,
  parameter int FAST_XTAL_CNT = osc_pkg::FAST_XTAL_CYC,
  parameter int SLOW_XTAL_CNT = osc_pkg::SLOW_XTAL_CYC
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire osc_pkg::ahb_req_s bus_req,
  input  wire logic [31:0]       hwdata,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic              xtal_pins_on,
  input  wire logic              halt_req,
  input  wire logic              wake_req,
  input  wire logic              wdt_enable,
  input  wire logic              wdt_timeout,
  output osc_pkg::clk_out_s      clk_out,
  output logic                   cpu_stopped,
  output logic                   wdt_clear,
  output logic                   wdt_run,
  output osc_pkg::pmode_e        power_mode
);
  import osc_pkg::*;

  typedef struct packed {
    logic        wr_pend;
    logic        rd_pend;
    logic [7:0]  addr;
    logic [31:0] rdata;
    logic [1:0]  int_fast_freq_code;
    logic        int_fast_enable;
    logic        int_fast_stable_flag;
    logic [12:0] int_fast_cnt;
    logic        crystal_drive_mode;
    logic        fast_crystal_enable;
    logic        fast_crystal_stable_flag;
    logic [12:0] fast_xtal_cnt;
    logic        slow_crystal_speedup;
    logic        slow_crystal_enable;
    logic        slow_crystal_stable_flag;
    logic [12:0] slow_xtal_cnt;
    logic [2:0]  sys_clock_select;
    logic        fast_source_select;
    logic        slow_source_select;
    logic        fast_osc_idle_enable;
    logic        slow_osc_idle_enable;
    logic        sys_slow;
    logic [2:0]  div_log2;
    freq_e       freq;
    logic        power_down_flag;
    logic        watchdog_timeout_flag;
    pmode_e      mode;
    logic        wdt_clr;
  } state_s;

  state_s s_q;
  state_s s_d;
  logic   fast_ok;
  logic   slow_ok;
  logic   take;
  logic [7:0] wb;

  // The selected fast source is ready only when its stable flag is up; the slow source is always ready unless its crystal is selected.
  assign fast_ok = s_q.fast_source_select ? s_q.fast_crystal_stable_flag : s_q.int_fast_stable_flag;
  assign slow_ok = s_q.slow_source_select ? s_q.slow_crystal_stable_flag : 1'b1;
  assign take    = bus_req.hsel & bus_req.hready & bus_req.htrans[1];
  assign wb      = hwdata[7:0];

  // Whole next-state computation; bus write lands one cycle after its address phase.
  always_comb begin
    s_d         = s_q;
    s_d.wdt_clr = 1'b0;
    s_d.wr_pend = take & bus_req.hwrite;
    s_d.rd_pend = take & ~bus_req.hwrite;
    if (take) begin
      s_d.addr = bus_req.haddr[7:0];
    end
    // Register writes in the data phase.
    if (s_q.wr_pend) begin
      if (s_q.addr == OFF_INT_FAST) begin
        if (wb[BIT_FREQ_LO +: 2] != s_q.int_fast_freq_code ||
            (wb[BIT_ENABLE] && !s_q.int_fast_enable)) begin
          s_d.int_fast_stable_flag = 1'b0;
          s_d.int_fast_cnt         = '0;
        end
        s_d.int_fast_freq_code = wb[BIT_FREQ_LO +: 2];
        s_d.int_fast_enable    = wb[BIT_ENABLE];
      end else if (s_q.addr == OFF_FAST_XTAL) begin
        if (!(xtal_pins_on && s_q.fast_crystal_enable)) begin
          s_d.crystal_drive_mode = wb[BIT_MODE];
        end
        if (wb[BIT_ENABLE] && !s_q.fast_crystal_enable) begin
          s_d.fast_crystal_stable_flag = 1'b0;
          s_d.fast_xtal_cnt            = '0;
        end
        s_d.fast_crystal_enable = wb[BIT_ENABLE];
      end else if (s_q.addr == OFF_SLOW_XTAL) begin
        if (!(s_q.sys_slow && s_q.slow_source_select)) begin
          s_d.slow_crystal_speedup = wb[BIT_MODE];
        end
        if (wb[BIT_ENABLE] && !s_q.slow_crystal_enable) begin
          s_d.slow_crystal_stable_flag = 1'b0;
          s_d.slow_xtal_cnt            = '0;
        end
        s_d.slow_crystal_enable = wb[BIT_ENABLE];
      end else if (s_q.addr == OFF_SYS_CLK) begin
        s_d.sys_clock_select     = wb[BIT_CKS_LO +: 3];
        s_d.fast_source_select   = wb[BIT_FAST_SRC];
        s_d.slow_source_select   = wb[BIT_SLOW_SRC];
        s_d.fast_osc_idle_enable = wb[BIT_FAST_IDLE];
        s_d.slow_osc_idle_enable = wb[BIT_SLOW_IDLE];
      end
    end
    // Stabilisation counters: flags rise once the count elapses while enabled.
    if (!s_q.int_fast_enable) begin
      s_d.int_fast_stable_flag = 1'b0;
      s_d.int_fast_cnt         = '0;
    end else if (s_d.int_fast_cnt == 13'(INT_FAST_CNT - 1)) begin // Reads s_d so a write restart wins.
      s_d.int_fast_stable_flag = 1'b1;
    end else if (!s_d.int_fast_stable_flag) begin
      s_d.int_fast_cnt = s_d.int_fast_cnt + 13'h1;
    end
    if (!s_q.fast_crystal_enable) begin
      s_d.fast_crystal_stable_flag = 1'b0;
      s_d.fast_xtal_cnt            = '0;
    end else if (s_q.fast_xtal_cnt == 13'(FAST_XTAL_CNT - 1)) begin
      s_d.fast_crystal_stable_flag = 1'b1;
    end else if (!s_q.fast_crystal_stable_flag) begin
      s_d.fast_xtal_cnt = s_q.fast_xtal_cnt + 13'h1;
    end
    // Speed-up halves the slow crystal's start-up, trading current for time.
    if (!s_q.slow_crystal_enable) begin
      s_d.slow_crystal_stable_flag = 1'b0;
      s_d.slow_xtal_cnt            = '0;
    end else if (s_q.slow_xtal_cnt >= 13'(s_q.slow_crystal_speedup ? SLOW_XTAL_CNT / 2 - 1
                                                                      : SLOW_XTAL_CNT - 1)) begin
      s_d.slow_crystal_stable_flag = 1'b1;
    end else if (!s_q.slow_crystal_stable_flag) begin
      s_d.slow_xtal_cnt = s_q.slow_xtal_cnt + 13'h1;
    end
    // The delivered frequency follows the code only once the oscillator is stable.
    if (s_q.int_fast_stable_flag) begin
      case (s_q.int_fast_freq_code)
        2'b01:   s_d.freq = FREQ_12M;
        2'b10:   s_d.freq = FREQ_16M;
        default: s_d.freq = FREQ_8M;
      endcase
    end
    // System clock switch: slow only when slow source ready, fast only when fast ready.
    if (s_q.sys_clock_select == CKS_SLOW) begin
      if (slow_ok) begin
        s_d.sys_slow = 1'b1;
      end
    end else if (fast_ok) begin
      s_d.sys_slow = 1'b0;
      s_d.div_log2 = s_q.sys_clock_select;
    end
    // Halt entry picks mode from the idle enables; wake returns to run.
    case (s_q.mode)
      MODE_RUN: begin
        if (halt_req) begin
          case ({s_q.fast_osc_idle_enable, s_q.slow_osc_idle_enable})
            2'b00:   s_d.mode = MODE_SLEEP;
            2'b01:   s_d.mode = MODE_IDLE_SLOW;
            2'b11:   s_d.mode = MODE_IDLE_BOTH;
            default: s_d.mode = MODE_IDLE_FAST;
          endcase
          s_d.power_down_flag       = 1'b1;
          s_d.watchdog_timeout_flag = 1'b0;
          s_d.wdt_clr               = 1'b1;
        end
      end
      default: begin
        if (wake_req) begin
          s_d.mode = MODE_RUN;
        end
      end
    endcase
    // A watchdog timeout sets its flag, winning over any clear in the same cycle.
    if (wdt_timeout) begin
      s_d.watchdog_timeout_flag = 1'b1;
    end
    // Read data captured in the address phase, upper bits zero.
    s_d.rdata = '0;
    if (take && !bus_req.hwrite) begin
      if (bus_req.haddr[7:0] == OFF_INT_FAST) begin
        s_d.rdata[3:0] = {s_q.int_fast_freq_code, s_q.int_fast_stable_flag, s_q.int_fast_enable};
      end else if (bus_req.haddr[7:0] == OFF_FAST_XTAL) begin
        s_d.rdata[2:0] = {s_q.crystal_drive_mode, s_q.fast_crystal_stable_flag, s_q.fast_crystal_enable};
      end else if (bus_req.haddr[7:0] == OFF_SLOW_XTAL) begin
        s_d.rdata[2:0] = {s_q.slow_crystal_speedup, s_q.slow_crystal_stable_flag, s_q.slow_crystal_enable};
      end else if (bus_req.haddr[7:0] == OFF_SYS_CLK) begin
        s_d.rdata[7:0] = {s_q.sys_clock_select, 1'b0, s_q.fast_source_select, s_q.slow_source_select,
                          s_q.fast_osc_idle_enable, s_q.slow_osc_idle_enable};
      end else if (bus_req.haddr[7:0] == OFF_STATUS) begin
        s_d.rdata[2:0] = {s_q.sys_slow, s_q.watchdog_timeout_flag, s_q.power_down_flag};
      end else if (bus_req.haddr[7:0] == OFF_HALT) begin
        s_d.rdata[2:0] = 3'(s_q.mode);
      end
    end
  end

  // State register; asynchronous reset loads constants only.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q                 <= '0;
      s_q.int_fast_enable <= RST_INT_FAST[BIT_ENABLE];
      s_q.freq            <= FREQ_8M;
      s_q.mode            <= MODE_RUN;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs: zero-wait slave, always OKAY.
  assign hrdata    = s_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign cpu_stopped = (s_q.mode != MODE_RUN);
  assign wdt_clear   = s_q.wdt_clr;
  assign wdt_run     = wdt_enable;
  assign power_mode  = s_q.mode;

  // Clock gating per mode: sleep stops both, idles keep what their bits ask.
  always_comb begin
    clk_out.fast_en       = s_q.int_fast_enable;
    clk_out.xtal_en       = s_q.fast_crystal_enable;
    clk_out.slow_en       = s_q.slow_crystal_enable;
    clk_out.fast_clk_on   = (s_q.mode == MODE_RUN) || (s_q.mode == MODE_IDLE_BOTH) || (s_q.mode == MODE_IDLE_FAST);
    clk_out.slow_clk_on   = (s_q.mode == MODE_RUN) || (s_q.mode == MODE_IDLE_BOTH) || (s_q.mode == MODE_IDLE_SLOW);
    clk_out.sys_slow      = s_q.sys_slow;
    clk_out.fast_div_log2 = s_q.div_log2;
    clk_out.freq          = s_q.freq;
  end

  // Checks.
  property p_halt_flags;
    @(posedge hclk) disable iff (!hresetn)
      (s_q.mode == MODE_RUN && halt_req && !wdt_timeout) |=> (s_q.power_down_flag && !s_q.watchdog_timeout_flag && wdt_clear);
  endproperty
  a_halt_flags: assert property (p_halt_flags) else $error("halt flags wrong");

  property p_sleep;
    @(posedge hclk) disable iff (!hresetn)
      (s_q.mode == MODE_RUN && halt_req && !s_q.fast_osc_idle_enable && !s_q.slow_osc_idle_enable)
        |=> (power_mode == MODE_SLEEP && !clk_out.fast_clk_on && !clk_out.slow_clk_on);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not entered");

  property p_idle_slow;
    @(posedge hclk) disable iff (!hresetn)
      (s_q.mode == MODE_RUN && halt_req && !s_q.fast_osc_idle_enable && s_q.slow_osc_idle_enable)
        |=> (!clk_out.fast_clk_on && clk_out.slow_clk_on);
  endproperty
  a_idle_slow: assert property (p_idle_slow) else $error("slow idle wrong");

  property p_idle_fast;
    @(posedge hclk) disable iff (!hresetn)
      (s_q.mode == MODE_RUN && halt_req && s_q.fast_osc_idle_enable && !s_q.slow_osc_idle_enable)
        |=> (clk_out.fast_clk_on && !clk_out.slow_clk_on && cpu_stopped);
  endproperty
  a_idle_fast: assert property (p_idle_fast) else $error("fast idle wrong");

  property p_slow_needs_stable;
    @(posedge hclk) disable iff (!hresetn)
      $rose(s_q.sys_slow) |-> $past(slow_ok) && $past(s_q.sys_clock_select) == CKS_SLOW;
  endproperty
  a_slow_needs_stable: assert property (p_slow_needs_stable) else $error("slow switch early");

  property p_fast_needs_stable;
    @(posedge hclk) disable iff (!hresetn)
      $fell(s_q.sys_slow) |-> $past(fast_ok);
  endproperty
  a_fast_needs_stable: assert property (p_fast_needs_stable) else $error("fast switch early");

  property p_freq_stable;
    @(posedge hclk) disable iff (!hresetn)
      !$stable(s_q.freq) |-> $past(s_q.int_fast_stable_flag);
  endproperty
  a_freq_stable: assert property (p_freq_stable) else $error("frequency moved unstable");

  property p_drive_lock;
    @(posedge hclk) disable iff (!hresetn)
      (xtal_pins_on && s_q.fast_crystal_enable) |=> $stable(s_q.crystal_drive_mode);
  endproperty
  a_drive_lock: assert property (p_drive_lock) else $error("drive mode changed while locked");

  property p_xtal_flag_clear;
    @(posedge hclk) disable iff (!hresetn)
      $rose(s_q.fast_crystal_enable) |-> !s_q.fast_crystal_stable_flag;
  endproperty
  a_xtal_flag_clear: assert property (p_xtal_flag_clear) else $error("crystal flag not cleared");

  property p_idle_both;
    @(posedge hclk) disable iff (!hresetn)
      (s_q.mode == MODE_RUN && halt_req && s_q.fast_osc_idle_enable && s_q.slow_osc_idle_enable)
        |=> (power_mode == MODE_IDLE_BOTH && clk_out.fast_clk_on && clk_out.slow_clk_on);
  endproperty
  a_idle_both: assert property (p_idle_both) else $error("both-clock idle wrong");

  // A code change while running must drop the flag even when the count had finished.
  property p_int_flag_restart;
    @(posedge hclk) disable iff (!hresetn)
      (s_q.wr_pend && s_q.addr == OFF_INT_FAST && s_q.int_fast_enable &&
       wb[BIT_FREQ_LO +: 2] != s_q.int_fast_freq_code) |=> !s_q.int_fast_stable_flag;
  endproperty
  a_int_flag_restart: assert property (p_int_flag_restart) else $error("fast flag not restarted");

  property p_slow_flag_clear;
    @(posedge hclk) disable iff (!hresetn)
      $rose(s_q.slow_crystal_enable) |-> !s_q.slow_crystal_stable_flag;
  endproperty
  a_slow_flag_clear: assert property (p_slow_flag_clear) else $error("slow flag not cleared");

  property p_speedup_lock;
    @(posedge hclk) disable iff (!hresetn)
      (s_q.sys_slow && s_q.slow_source_select) |=> $stable(s_q.slow_crystal_speedup);
  endproperty
  a_speedup_lock: assert property (p_speedup_lock) else $error("speed-up changed while locked");

  property p_upper_zero;
    @(posedge hclk) disable iff (!hresetn)
      hrdata[31:8] == 24'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");

  property p_wdt_pulse;
    @(posedge hclk) disable iff (!hresetn)
      wdt_clear |=> !wdt_clear;
  endproperty
  a_wdt_pulse: assert property (p_wdt_pulse) else $error("watchdog clear too long");

  // Halt entry without a concurrent write leaves the configuration untouched.
  property p_halt_keeps;
    @(posedge hclk) disable iff (!hresetn)
      (s_q.mode == MODE_RUN && halt_req && !s_q.wr_pend)
        |=> ($stable(s_q.sys_clock_select) && $stable(s_q.int_fast_freq_code) && cpu_stopped);
  endproperty
  a_halt_keeps: assert property (p_halt_keeps) else $error("state lost on halt");

  property p_flag_readonly;
    @(posedge hclk) disable iff (!hresetn)
      (s_q.wr_pend && s_q.addr == OFF_INT_FAST && s_q.int_fast_enable && wb[BIT_ENABLE] &&
       wb[BIT_FREQ_LO +: 2] == s_q.int_fast_freq_code && s_q.int_fast_stable_flag) |=> s_q.int_fast_stable_flag;
  endproperty
  a_flag_readonly: assert property (p_flag_readonly) else $error("stable flag written");

endmodule // osc_ctrl

/* tb/osc_control_and_power_modes_test.sv */
/*
  Self-checking bench for the oscillator and power-mode controller.
  Assumes the controller is the only AHB-Lite slave, answers with zero wait
  states, and that its counts are shortened to 8 cycles for a quick run.
*/
`timescale 1ns/1ps
module osc_control_and_power_modes_test;
  import osc_pkg::*;
  logic              hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0]       haddr, hwdata, hrdata, rnd;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic              xtal_pins_on, halt_req, wake_req, wdt_enable, wdt_timeout;
  logic              cpu_stopped, wdt_clear, wdt_run;
  ahb_req_s          bus_req;
  clk_out_s          clk_out;
  pmode_e            power_mode;
  int                err_count, n_tests, cyc;
  // Model of the delivered frequency per code, and of the mode per idle bits.
  logic [1:0]        freq_m [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
  logic [2:0]        mode_m [4] = '{3'h1, 3'h2, 3'h4, 3'h3};

  // The slave's own ready is the bus ready, as with a single slave.
  assign bus_req = {hsel, haddr, htrans, hwrite, hsize, hreadyout};

  osc_ctrl #(.INT_FAST_CNT(8), .FAST_XTAL_CNT(8), .SLOW_XTAL_CNT(8)) DUT (
    .hclk(hclk), .hresetn(hresetn), .bus_req(bus_req), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .xtal_pins_on(xtal_pins_on), .halt_req(halt_req),
    .wake_req(wake_req), .wdt_enable(wdt_enable), .wdt_timeout(wdt_timeout), .clk_out(clk_out),
    .cpu_stopped(cpu_stopped), .wdt_clear(wdt_clear), .wdt_run(wdt_run), .power_mode(power_mode)
  );

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One single word transfer; the address phase holds until ready is sampled.
  task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= addr;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    rnd = lfsr(rnd);
  endtask

  task automatic wr(input logic [31:0] addr, input logic [31:0] wd);
    logic [31:0] d;
    xfer(1'b1, addr, wd, d);
  endtask

  task automatic rd_chk(input logic [31:0] addr, input logic [31:0] exp);
    logic [31:0] d;
    xfer(1'b0, addr, 32'h0, d);
    chk("rdata", exp, d);
  endtask

  // Polls a stable flag with a bounded number of reads.
  task automatic poll(input logic [31:0] addr, input int bitn);
    logic [31:0] d;
    int          i;
    i = 0;
    do begin
      xfer(1'b0, addr, 32'h0, d);
      i++;
    end while (d[bitn] !== 1'b1 && i < 100);
  endtask

  task automatic pulse(input int which);
    @(posedge hclk);
    if (which == 0) halt_req <= 1'b1;
    else if (which == 1) wake_req <= 1'b1;
    else wdt_timeout <= 1'b1;
    @(posedge hclk);
    halt_req    <= 1'b0;
    wake_req    <= 1'b0;
    wdt_timeout <= 1'b0;
    #1;
  endtask

  // A hang shows up as a run far past the expected length.
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      $display("MISMATCH timeout expected 0 seen 1");
      stop_test();
    end
  end

  initial begin
    int          k;
    logic [31:0] d;
    err_count = 0; n_tests = 0; cyc = 0; rnd = 32'hbe1d;
    hresetn = 1'b0; hsel = 1'b0; hwrite = 1'b0; haddr = 32'h0; hwdata = 32'h0;
    htrans = 2'h0; hsize = 3'h2; xtal_pins_on = 1'b1; halt_req = 1'b0;
    wake_req = 1'b0; wdt_enable = 1'b0; wdt_timeout = 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values; the flag bit of the first register is left out.
    xfer(1'b0, 32'h00, 32'h0, d);
    chk("int_fast_rst", 32'h1, d & 32'hfffffffd);
    chk("fast_en", 32'h1, clk_out.fast_en);
    rd_chk(32'h04, 32'h0);
    rd_chk(32'h08, 32'h0);
    rd_chk(32'h0c, 32'h0);
    wr(32'h40, rnd);
    rd_chk(32'h40, 32'h0);
    // Frequency codes; junk in upper bits and in the flag bit is dropped.
    wr(32'h00, 32'h0);
    for (k = 1; k <= 4; k++) begin
      wr(32'h00, (rnd & 32'hfffffff0) | ((k % 4) << 2) | 3);
      rd_chk(32'h00, ((k % 4) << 2) | 1);
      chk("freq_hold", freq_m[k - 1], clk_out.freq);
      poll(32'h00, 1);
      rd_chk(32'h00, ((k % 4) << 2) | 3);
      chk("freq", freq_m[k % 4], clk_out.freq);
    end
    // Fast crystal: drive mode set first, then locked while pins and enable are on.
    wr(32'h04, 32'h4);
    rd_chk(32'h04, 32'h4);
    wr(32'h04, 32'h5);
    rd_chk(32'h04, 32'h5);
    poll(32'h04, 1);
    rd_chk(32'h04, 32'h7);
    wr(32'h04, 32'hf9);
    rd_chk(32'h04, 32'h7);
    xtal_pins_on <= 1'b0;
    wr(32'h04, 32'h1);
    rd_chk(32'h04, 32'h3);
    chk("xtal_en", 1'b1, clk_out.xtal_en);
    // Slow crystal: start, set speed-up, select it, then speed-up is locked.
    wr(32'h08, 32'h1);
    rd_chk(32'h08, 32'h1);
    chk("slow_en", 32'h1, clk_out.slow_en);
    poll(32'h08, 1);
    wr(32'h08, 32'h5);
    rd_chk(32'h08, 32'h7);
    wr(32'h0c, 32'he4);
    rd_chk(32'h0c, 32'he4);
    chk("sys_slow", 1'b1, clk_out.sys_slow);
    wr(32'h08, 32'h3);
    rd_chk(32'h08, 32'h7);
    // Every divide code of the fast clock.
    for (k = 0; k < 7; k++) begin
      wr(32'h0c, k << 5);
      repeat (4) @(posedge hclk);
      #1;
      chk("div", k, clk_out.fast_div_log2);
      chk("sys_fast", 1'b0, clk_out.sys_slow);
    end
    // Return to fast with the fast oscillator stopped must wait for it.
    wr(32'h0c, 32'he0);
    wr(32'h00, 32'h0);
    wr(32'h0c, 32'h0);
    repeat (20) @(posedge hclk);
    #1;
    chk("slow_wait", 1'b1, clk_out.sys_slow);
    wr(32'h00, 32'h1);
    chk("slow_wait2", 1'b1, clk_out.sys_slow);
    poll(32'h00, 1);
    repeat (4) @(posedge hclk);
    #1;
    chk("back_fast", 1'b0, clk_out.sys_slow);
    // Each halt mode: flags, watchdog clear and clock gating.
    for (k = 0; k < 4; k++) begin
      wr(32'h0c, k);
      wdt_enable <= rnd[0];
      pulse(2);
      rd_chk(32'h10, (k == 0) ? 32'h2 : 32'h3);
      pulse(0);
      chk("wdt_clear", 1'b1, wdt_clear);
      chk("mode", mode_m[k], power_mode);
      chk("stopped", 1'b1, cpu_stopped);
      chk("fast_on", k >> 1, clk_out.fast_clk_on);
      chk("slow_on", k & 1, clk_out.slow_clk_on);
      chk("wdt_run", wdt_enable, wdt_run);
      @(posedge hclk);
      #1;
      chk("wdt_pulse", 1'b0, wdt_clear);
      xfer(1'b0, 32'h10, 32'h0, d);
      chk("status", 32'h1, d & 32'h3);
      rd_chk(32'h0c, k);
      pulse(1);
      repeat (2) @(posedge hclk);
      #1;
      chk("wake", 1'b0, cpu_stopped);
    end
    stop_test();
  end
endmodule // osc_control_and_power_modes_test
